// ===== testbench/test_tof_result_register_bank.sv
`timescale 1ns/1ns
module test_tof_result_register_bank;
	logic              i_mclk   = 1'b0;
	logic              i_arst_n = 1'b0;
	logic              i_rd_en  = 1'b0;
	logic              i_wr_en  = 1'b0;
	logic [7:0]        i_addr   = 8'h00;
	trb_pkg::trb_upd_s upd;
	logic              clr;
	trb_pkg::trb_rsp_s o_rsp;
	logic              o_wr_ignored;
	int                error_cnt  = 0;
	int                n_compared = 0;
	// 250 MHz clock
	always #2 i_mclk = ~i_mclk;
	trb_engine_model u_eng (.i_mclk(i_mclk), .o_upd(upd), .o_clear(clr));
	trb_result_bank u_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_upd(upd),
		.i_clear(clr), .i_rd_en(i_rd_en), .i_wr_en(i_wr_en), .i_addr(i_addr),
		.o_rsp(o_rsp), .o_wr_ignored(o_wr_ignored));
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Read answer must come exactly one cycle later
	task automatic rd(input logic [7:0] a, input logic [23:0] exp);
		@(posedge i_mclk);
		#1 i_rd_en = 1'b1;
		i_addr = a;
		@(posedge i_mclk);
		#1 i_rd_en = 1'b0;
		chk("rsp_valid", 24'h1, {23'h0, o_rsp.valid});
		chk($sformatf("entry_%h", a), exp, o_rsp.data);
	endtask : rd
	// Word for entry i: counts drop bits 22..16, other entries keep all
	function automatic logic [23:0] expv(input int i, input logic [23:0] d);
		return (i == 1 || i == 3 || i == 5) ? {d[23], 7'h00, d[15:0]} : d;
	endfunction : expv
	function automatic logic [23:0] word(input int i);
		return {1'b1, 7'h55, 8'ha0 + 8'(i), 8'h3c};
	endfunction : word
	task automatic t_reset();
		i_arst_n = 1'b0;
		repeat (5) @(posedge i_mclk);
		#1 i_arst_n = 1'b1;
		for (int i = 0; i < 8; i++) rd(8'h14 + 8'(i), 24'h000000);
		$display("reset test done");
	endtask : t_reset
	// Fill every entry first so a decode alias overwrites a neighbour
	task automatic t_map();
		for (int i = 0; i < 8; i++) u_eng.post(8'h14 + 8'(i), word(i));
		// Addresses just outside the bank must change nothing
		u_eng.post(8'h13, 24'hffffff);
		u_eng.post(8'h1c, 24'hffffff);
		for (int i = 0; i < 8; i++) rd(8'h14 + 8'(i), expv(i, word(i)));
		$display("map test done");
	endtask : t_map
	task automatic t_write();
		@(posedge i_mclk);
		#1 i_wr_en = 1'b1;
		i_addr = 8'h18;
		@(posedge i_mclk);
		#1 i_wr_en = 1'b0;
		chk("wr_ignored", 24'h1, {23'h0, o_wr_ignored});
		rd(8'h18, word(4));
		rd(8'h18, word(4));
		// Answer word stands after the valid pulse
		@(posedge i_mclk);
		#1;
		chk("rsp_valid_low", 24'h000000, {23'h0, o_rsp.valid});
		chk("rsp_hold", word(4), o_rsp.data);
		rd(8'h20, 24'h000000);
		rd(8'h13, 24'h000000);
		rd(8'h1c, 24'h000000);
		$display("write test done");
	endtask : t_write
	task automatic t_clear();
		// Update in the clear cycle keeps its own entry, the rest clear
		u_eng.post_clear(8'h19, word(5));
		rd(8'h19, expv(5, word(5)));
		rd(8'h1a, 24'h000000);
		u_eng.wipe();
		rd(8'h14, 24'h000000);
		rd(8'h19, 24'h000000);
		$display("clear test done");
	endtask : t_clear
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// Main sequence, second reset in mid-run
	initial begin
		t_reset();
		t_map();
		t_write();
		t_reset();
		t_map();
		t_clear();
		finish_test();
	end
	// Watchdog, far beyond the about 140 cycles needed
	initial begin
		#20000;
		error_cnt++;
		finish_test();
	end
endmodule : test_tof_result_register_bank

// ===== testbench/trb_engine_model.sv
`timescale 1ns/1ns
// Engine stand-in: one-cycle updates and clears
module trb_engine_model (
	input  wire logic         i_mclk,
	output trb_pkg::trb_upd_s o_upd,
	output logic              o_clear
);
	// Idle at time zero
	initial begin
		o_upd   = '0;
		o_clear = 1'b0;
	end
	// Idle payload inverted so a stale word never matches
	task automatic post(input logic [7:0] a, input logic [23:0] d);
		@(posedge i_mclk);
		#1 o_upd = {1'b1, a, d};
		@(posedge i_mclk);
		#1 o_upd = {1'b0, ~a, ~d};
	endtask : post
	// Clear and update in one cycle; the update keeps its entry
	task automatic post_clear(input logic [7:0] a, input logic [23:0] d);
		@(posedge i_mclk);
		#1 o_upd = {1'b1, a, d};
		o_clear = 1'b1;
		@(posedge i_mclk);
		#1 o_upd = {1'b0, ~a, ~d};
		o_clear = 1'b0;
	endtask : post_clear
	// Clear of all entries
	task automatic wipe();
		@(posedge i_mclk);
		#1 o_clear = 1'b1;
		@(posedge i_mclk);
		#1 o_clear = 1'b0;
	endtask : wipe
endmodule : trb_engine_model

// ===== verilog/trb_pkg.sv
package trb_pkg;

	// Entry geometry
	localparam int unsigned TRB_DATA_W      = 24;
	localparam int unsigned TRB_ADDR_W      = 8;
	localparam int unsigned TRB_NUM_ENTRIES = 8;
	localparam int unsigned TRB_IDX_W       = 3;

	// Field positions
	localparam int unsigned TRB_PARITY_BIT  = 23;
	localparam int unsigned TRB_INT_MSB     = 22;
	localparam int unsigned TRB_CNT_MSB     = 15;
	localparam int unsigned TRB_RSVD_LSB    = 16;
	localparam int unsigned TRB_RSVD_MSB    = 22;

	// Values after reset and field masks
	localparam logic [23:0] TRB_RESET_VAL   = 24'h000000;
	localparam logic [23:0] TRB_COUNT_MASK  = 24'h80ffff;
	localparam logic [6:0]  TRB_RSVD_ZERO   = 7'h00;

	// Result entry addresses, interval and count alternating up to 1Ah, calibration at 1Bh
	localparam logic [7:0]  TRB_ADDR_INT3   = 8'h14;
	localparam logic [7:0]  TRB_ADDR_CNT3   = 8'h15;
	localparam logic [7:0]  TRB_ADDR_INT4   = 8'h16;
	localparam logic [7:0]  TRB_ADDR_CNT4   = 8'h17;
	localparam logic [7:0]  TRB_ADDR_INT5   = 8'h18;
	localparam logic [7:0]  TRB_ADDR_CNT5   = 8'h19;
	localparam logic [7:0]  TRB_ADDR_INT6   = 8'h1a;
	localparam logic [7:0]  TRB_ADDR_CAL1   = 8'h1b;
	localparam logic [7:0]  TRB_ADDR_FIRST  = TRB_ADDR_INT3;
	localparam logic [7:0]  TRB_ADDR_LAST   = TRB_ADDR_CAL1;

	// Bit i set where entry FIRST+i is a clock-count entry
	localparam logic [7:0]  TRB_COUNT_MAP   = 8'h2a;

	// Read answer latency in clock cycles
	localparam int unsigned TRB_RD_LATENCY  = 1;

	// Update from the measurement engine
	typedef struct packed {
		logic        valid;
		logic [7:0]  addr;
		logic [23:0] data;
	} trb_upd_s;

	// Read answer to the serial front end
	typedef struct packed {
		logic        valid;
		logic [23:0] data;
	} trb_rsp_s;

endpackage : trb_pkg

// ===== verilog/trb_result_bank.sv
`timescale 1ns/1ns
module trb_result_bank #(
	parameter int unsigned DATA_W = trb_pkg::TRB_DATA_W
) (
	input  wire logic              i_mclk,
	input  wire logic              i_arst_n,
	input  wire trb_pkg::trb_upd_s i_upd,
	input  wire logic              i_clear,
	input  wire logic              i_rd_en,
	input  wire logic              i_wr_en,
	input  wire logic [7:0]        i_addr,
	output trb_pkg::trb_rsp_s      o_rsp,
	output logic                   o_wr_ignored
);

	localparam int unsigned N = trb_pkg::TRB_NUM_ENTRIES;

	logic [N-1:0][DATA_W-1:0] entry_val;
	logic [N-1:0]             entry_load;
	logic [7:0]               rd_off;
	logic [2:0]               rd_idx;
	logic                     rd_hit;
	logic [DATA_W-1:0]        rd_word;
	trb_pkg::trb_rsp_s        rsp_q;
	logic                     wr_ign_q;
	logic                     upd_in_bank;
	logic                     seen_q;

	// One entry per address, FIRST+i; kind from the count map
	generate
		for (genvar i = 0; i < N; i++) begin : g_entry
			assign entry_load[i] = i_upd.valid &&
				(i_upd.addr == 8'(int'(trb_pkg::TRB_ADDR_FIRST) + i));

			trb_result_entry #(
				.IS_COUNT (trb_pkg::TRB_COUNT_MAP[i]),
				.DATA_W   (DATA_W)
			) u_entry (
				.i_mclk   (i_mclk),
				.i_arst_n (i_arst_n),
				.i_clear  (i_clear),
				.i_load   (entry_load[i]),
				.i_data   (i_upd.data[DATA_W-1:0]),
				.o_value  (entry_val[i])
			);
		end
	endgenerate

	// Host address decode; outside the bank reads as zero
	assign rd_off = i_addr - trb_pkg::TRB_ADDR_FIRST;
	assign rd_idx = rd_off[2:0];
	assign rd_hit = (i_addr >= trb_pkg::TRB_ADDR_FIRST) &&
	                (i_addr <= trb_pkg::TRB_ADDR_LAST);

	// Engine address range, kept apart from the per-entry decode for checking
	assign upd_in_bank = (i_upd.addr >= trb_pkg::TRB_ADDR_FIRST) &&
	                     (i_upd.addr <= trb_pkg::TRB_ADDR_LAST);

	// Read mux is pure selection so reads have no side effect
	always_comb begin
		rd_word = '0;
		if (rd_hit) begin
			rd_word = entry_val[rd_idx];
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rsp_q <= '0;
		end else begin
			rsp_q.valid <= i_rd_en;
			if (i_rd_en) begin
				rsp_q.data <= 24'(rd_word);
			end
		end
	end

	// writes dropped, flagged for the front end
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ign_q <= 1'b0;
		end else begin
			wr_ign_q <= i_wr_en;
		end
	end

	assign o_rsp        = rsp_q;
	assign o_wr_ignored = wr_ign_q;

	// First cycle after release, read by the checks only
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= 1'b1;
		end
	end

	// Checks; data held in the answer register between reads
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);

	AST_RD_DATA: assert property (i_rd_en && rd_hit |=>
		o_rsp.valid && o_rsp.data == $past(rd_word))
		else $error("read answer does not match stored entry");

	AST_RD_UNMAPPED: assert property (i_rd_en && !rd_hit |=> o_rsp.data == 24'h000000)
		else $error("unmapped read not zero");

	AST_RSP_PULSE: assert property (!i_rd_en |=> !o_rsp.valid)
		else $error("read answer without request");

	AST_WR_IGNORED: assert property (i_wr_en && !i_upd.valid && !i_clear |=>
		$stable(entry_val) && o_wr_ignored)
		else $error("host write altered the bank");

	AST_ADDR_INT3: assert property (i_upd.valid && i_upd.addr == 8'h14 |=>
		entry_val[0] == $past(i_upd.data))
		else $error("third interval not at 14h");

	AST_ADDR_CNT3: assert property (i_upd.valid && i_upd.addr == 8'h15 |=>
		entry_val[1] == ($past(i_upd.data) & 24'h80ffff))
		else $error("third count not at 15h");

	AST_ADDR_CNT45: assert property (i_upd.valid &&
		(i_upd.addr == 8'h17 || i_upd.addr == 8'h19) |=>
		entry_val[3][22:16] == 7'h00 && entry_val[5][22:16] == 7'h00 &&
		(entry_val[3] == ($past(i_upd.data) & 24'h80ffff) ||
		 entry_val[5] == ($past(i_upd.data) & 24'h80ffff)))
		else $error("fourth or fifth count misplaced");

	AST_ADDR_INT5: assert property (i_upd.valid && i_upd.addr == 8'h18 |=>
		entry_val[4] == $past(i_upd.data))
		else $error("fifth interval not at 18h");

	AST_ADDR_INT6: assert property (i_upd.valid && i_upd.addr == 8'h1a && !i_clear |=>
		entry_val[6] == $past(i_upd.data) && $stable(entry_val[7]))
		else $error("sixth interval not at 1Ah");

	AST_ADDR_CAL1: assert property (i_upd.valid && i_upd.addr == 8'h1b |=>
		entry_val[7] == $past(i_upd.data))
		else $error("first calibration not at 1Bh");

	AST_RD_NO_SIDE: assert property (i_rd_en && !i_upd.valid && !i_clear |=>
		$stable(entry_val))
		else $error("read altered the bank");

	AST_INT_FULL: assert property (i_upd.valid && i_upd.addr == 8'h16 |=>
		entry_val[2] == $past(i_upd.data))
		else $error("interval word not kept whole");

	// Outputs idle on the first edge after release
	AST_RST_OUTPUTS: assert property (!seen_q |-> o_rsp == '0 && !o_wr_ignored)
		else $error("outputs not idle after reset");

	// Every read is answered, mapped or not
	AST_RD_VALID: assert property (i_rd_en |=> o_rsp.valid)
		else $error("read request without answer");

	// Host may fetch the word late, so it stands until the next read
	AST_RSP_HOLD: assert property (!i_rd_en |=> $stable(o_rsp.data))
		else $error("answer word changed without a read");

	// Engine clear leaves the last answer for the host
	AST_CLEAR_RSP: assert property (i_clear && !i_rd_en |=> $stable(o_rsp.data))
		else $error("clear disturbed the answer word");

	// Flag only follows a write attempt
	AST_WR_PULSE: assert property (!i_wr_en |=> !o_wr_ignored)
		else $error("write flag without a write");

	// Clear alone empties the whole bank
	AST_CLEAR_ALL: assert property (i_clear && !i_upd.valid |=> entry_val == '0)
		else $error("clear left an entry set");

	// Neighbouring addresses are the usual decode alias
	AST_UPD_OUTSIDE: assert property (i_upd.valid && !upd_in_bank && !i_clear |=>
		$stable(entry_val))
		else $error("update outside the bank altered an entry");

	// Reserved count bits stay clear on the host side too
	AST_CNT_RD_RSVD: assert property (i_rd_en && rd_hit &&
		trb_pkg::TRB_COUNT_MAP[rd_idx] |=> o_rsp.data[22:16] == 7'h00)
		else $error("count entry read with reserved bits set");

	// Per-entry checks, each address tried against its own entry only
	generate
		for (genvar k = 0; k < N; k++) begin : g_chk
			localparam logic [7:0]  OWN_ADDR = 8'(int'(trb_pkg::TRB_ADDR_FIRST) + k);
			localparam logic [23:0] KEEP     = trb_pkg::TRB_COUNT_MAP[k] ?
			                                   trb_pkg::TRB_COUNT_MASK : 24'hffffff;

			// An update for this address lands here, count bits masked
			AST_ENTRY_OWN_LOAD: assert property (i_upd.valid &&
				i_upd.addr == OWN_ADDR |=> entry_val[k] == ($past(i_upd.data) & KEEP))
				else $error("entry did not load its own address");

			// Aliasing hazard: another address must not reach this entry
			AST_ENTRY_OWN_ONLY: assert property (i_upd.valid &&
				i_upd.addr != OWN_ADDR && !i_clear |=> $stable(entry_val[k]))
				else $error("entry changed by another address");

			// Host read of this address returns this entry
			AST_ENTRY_OWN_READ: assert property (i_rd_en &&
				i_addr == OWN_ADDR |=> o_rsp.data == $past(entry_val[k]))
				else $error("read returned a different entry");

			// Zero in the first cycle after release
			AST_ENTRY_OWN_RESET: assert property (!seen_q |-> entry_val[k] == '0)
				else $error("entry not zero after release");
		end
	endgenerate

endmodule : trb_result_bank

// ===== verilog/trb_result_entry.sv
`timescale 1ns/1ns
module trb_result_entry #(
	parameter bit          IS_COUNT = 1'b0,
	parameter int unsigned DATA_W   = 24
) (
	input  wire logic              i_mclk,
	input  wire logic              i_arst_n,
	input  wire logic              i_clear,
	input  wire logic              i_load,
	input  wire logic [DATA_W-1:0] i_data,
	output logic      [DATA_W-1:0] o_value
);

	logic [DATA_W-1:0] value_q;
	logic [DATA_W-1:0] value_d;
	logic [DATA_W-1:0] masked;
	logic              seen_q;

	// Count entries keep parity and low count only
	generate
		if (IS_COUNT) begin : g_cnt
			assign masked = i_data & DATA_W'(trb_pkg::TRB_COUNT_MASK);
		end else begin : g_int
			assign masked = i_data;
		end
	endgenerate

	// Engine load wins over a clear in the same cycle
	always_comb begin
		value_d = value_q;
		if (i_load) begin
			value_d = masked;
		end else if (i_clear) begin
			value_d = DATA_W'(trb_pkg::TRB_RESET_VAL);
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			value_q <= DATA_W'(trb_pkg::TRB_RESET_VAL);
		end else begin
			value_q <= value_d;
		end
	end

	// First cycle after release, for checking only
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= 1'b1;
		end
	end

	assign o_value = value_q;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);

	AST_ENTRY_RESET_ZERO: assert property (!seen_q |-> o_value == '0)
		else $error("entry not zero after reset");

	AST_ENTRY_HOLD: assert property (!i_load && !i_clear |=> $stable(o_value))
		else $error("entry changed without engine update");

	AST_ENTRY_LOAD: assert property (i_load |=> o_value == $past(masked))
		else $error("entry did not take engine data");

	AST_ENTRY_CLEAR: assert property (i_clear && !i_load |=> o_value == '0)
		else $error("entry not cleared");

	generate
		if (IS_COUNT) begin : g_chk
			AST_ENTRY_RSVD: assert property (o_value[22:16] == 7'h00)
				else $error("reserved count bits not zero");
		end
	endgenerate

endmodule : trb_result_entry
